// *** core/ocd_amp_cal.v ***
// amplitude calibration stepper: walks the amplitude code upward
// assumes: amp_target from analog comparator, same clock domain
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_amp_cal (
  input  wire       clock,
  input  wire       rst,
  input  wire       start,       // one-cycle request to calibrate
  input  wire       override,    // use manual code, no search
  input  wire [8:0] start_code,  // search origin
  input  wire [8:0] manual_code, // programmed amplitude
  input  wire       amp_target,  // level: amplitude reached
  output reg  [8:0] code_q,      // code applied to the oscillator
  output reg        busy_q       // search running
);
  // search step: upward, stopping at target or upper limit
  always @(posedge clock) begin
    if (rst) begin
      code_q <= `OCD_AMP_CODE_RST;
      busy_q <= 1'b0;
    end else if (override) begin
      code_q <= manual_code;
      busy_q <= 1'b0;
    end else if (start) begin
      code_q <= start_code;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (amp_target || code_q >= `OCD_AMP_MAX) begin
        busy_q <= 1'b0;
      end else begin
        code_q <= code_q + 9'h001;
      end
    end
  end
endmodule // ocd_amp_cal

// *** core/ocd_freq_cal.v ***
// frequency calibration core walker: starts at a core, steps downward
// assumes: freq_target from frequency comparator, same clock domain
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_freq_cal (
  input  wire       clock,
  input  wire       rst,
  input  wire       start,        // one-cycle request to calibrate
  input  wire       start_core_en,// begin at chosen core
  input  wire [2:0] core_choice,  // chosen start core
  input  wire       freq_target,  // level: frequency reached in core
  output reg  [2:0] core_q,       // core under test
  output reg        busy_q        // search running
);
  // core walk, highest core first by default
  always @(posedge clock) begin
    if (rst) begin
      core_q <= `OCD_DEFAULT_CORE;
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      if (start_core_en) begin
        core_q <= core_choice;
      end else begin
        core_q <= `OCD_DEFAULT_CORE;
      end
    end else if (busy_q) begin
      if (freq_target || core_q == 3'h0) begin
        busy_q <= 1'b0;
      end else begin
        core_q <= core_q - 3'h1;
      end
    end
  end
endmodule // ocd_freq_cal

// *** core/ocd_regs.v ***
// oscillator calibration and distribution register slice
// assumes: plain register port, read data one cycle after read strobe;
// analog comparators deliver amp_target and freq_target on this clock
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_regs (
  input  wire        clock,
  input  wire        rst,
  input  wire [4:0]  addr,          // register index
  input  wire [15:0] wdata,         // write data
  input  wire        wr,            // write strobe
  input  wire        rd,            // read strobe
  input  wire        amp_cal_start, // one-cycle: begin amplitude search
  input  wire        freq_cal_start,// one-cycle: begin frequency search
  input  wire        amp_target,    // amplitude reached
  input  wire        freq_target,   // frequency reached
  output reg  [15:0] rdata,         // read data, cycle after rd
  output reg  [8:0]  osc_amplitude_code,
  output reg  [2:0]  osc_core,      // core in use
  output reg  [7:0]  cap_bank_code, // capacitor code applied
  output reg         modulator_dither,
  output reg  [1:0]  tuning_adjust,
  output reg         out_b_direct_buf_pd,
  output reg         out_a_direct_buf_pd,
  output reg         divider_feed_buf_pd
);
  // stored registers, whole 16 bits kept so map defaults read back
  reg [15:0] amp_start_q;   // start code
  reg [15:0] cap_bank_q;    // manual capacitor code
  reg [15:0] core_sel_q;    // core select and force
  reg [15:0] fixed_a_q;     // fixed configuration words
  reg [15:0] fixed_b_q;
  reg [15:0] fixed_c_q;
  reg [15:0] fixed_d_q;
  reg [15:0] mod_tune_q;    // dither and tuning adjust
  reg [15:0] dist_pd_q;     // distribution power downs
  reg [15:0] cal_ctrl_q;    // overrides, enables, manual amplitude

  // decoded controls
  wire       amp_ovr    = cal_ctrl_q[`OCD_AMP_OVR_BIT];
  wire       cap_ovr    = cal_ctrl_q[`OCD_CAP_OVR_BIT];
  wire       amp_cal_en = cal_ctrl_q[`OCD_AMP_CAL_EN_BIT];
  wire       frq_cal_en = cal_ctrl_q[`OCD_FREQ_CAL_EN_BIT];
  wire       force_sel  = core_sel_q[`OCD_FORCE_BIT];
  wire [2:0] core_choice = core_sel_q[`OCD_CORE_HI:`OCD_CORE_LO];

  // calibration engine outputs
  wire [8:0] amp_code;
  wire       amp_busy;
  wire [2:0] cal_core;
  wire       frq_busy;

  // hit test used by the write decode; the read mux decodes with a case
  function hit;
    input [4:0] a;
    input [4:0] idx;
    begin
      hit = (a == idx);
    end
  endfunction

  // register writes
  always @(posedge clock) begin
    if (rst) begin
      amp_start_q <= `OCD_RST_AMP_START;
      cap_bank_q  <= `OCD_RST_CAP_BANK;
      core_sel_q  <= `OCD_RST_CORE_SEL;
      fixed_a_q   <= `OCD_RST_ZERO;
      fixed_b_q   <= `OCD_RST_ZERO;
      fixed_c_q   <= `OCD_RST_ZERO;
      fixed_d_q   <= `OCD_RST_ZERO;
      mod_tune_q  <= `OCD_RST_ZERO;
      dist_pd_q   <= `OCD_RST_DIST_PD;
      cal_ctrl_q  <= `OCD_RST_CAL_CTRL;
    end else if (wr) begin
      if (hit(addr, `OCD_IDX_AMP_START)) begin
        amp_start_q <= wdata;
      end
      if (hit(addr, `OCD_IDX_CAP_BANK)) begin
        cap_bank_q <= wdata;
      end
      if (hit(addr, `OCD_IDX_CORE_SEL)) begin
        core_sel_q <= wdata;
      end
      if (hit(addr, `OCD_IDX_FIXED_A)) begin
        fixed_a_q <= wdata;
      end
      if (hit(addr, `OCD_IDX_FIXED_B)) begin
        fixed_b_q <= wdata;
      end
      if (hit(addr, `OCD_IDX_FIXED_C)) begin
        fixed_c_q <= wdata;
      end
      if (hit(addr, `OCD_IDX_FIXED_D)) begin
        fixed_d_q <= wdata;
      end
      if (hit(addr, `OCD_IDX_MOD_TUNE)) begin
        mod_tune_q <= wdata;
      end
      if (hit(addr, `OCD_IDX_DIST_PD)) begin
        dist_pd_q <= wdata;
      end
      if (hit(addr, `OCD_IDX_CAL_CTRL)) begin
        cal_ctrl_q <= wdata;
      end
    end
  end

  // amplitude engine; request gated by its enable
  ocd_amp_cal u_amp (
    .clock       (clock),
    .rst         (rst),
    .start       (amp_cal_start & amp_cal_en),
    .override    (amp_ovr),
    .start_code  (amp_start_q[`OCD_AMP_START_HI:`OCD_AMP_START_LO]),
    .manual_code (cal_ctrl_q[`OCD_AMP_CODE_HI:`OCD_AMP_CODE_LO]),
    .amp_target  (amp_target),
    .code_q      (amp_code),
    .busy_q      (amp_busy)
  );

  // frequency engine; blocked while capacitor override is set
  ocd_freq_cal u_frq (
    .clock         (clock),
    .rst           (rst),
    .start         (freq_cal_start & frq_cal_en & ~cap_ovr),
    .start_core_en (core_sel_q[`OCD_START_CORE_BIT]),
    .core_choice   (core_choice),
    .freq_target   (freq_target),
    .core_q        (cal_core),
    .busy_q        (frq_busy)
  );

  // applied oscillator settings, all registered
  always @(posedge clock) begin
    if (rst) begin
      osc_amplitude_code <= `OCD_AMP_CODE_RST;
      osc_core           <= `OCD_DEFAULT_CORE;
      cap_bank_code      <= `OCD_RST_CAP_CODE;
    end else begin
      osc_amplitude_code <= amp_code;
      if (cap_ovr && force_sel) begin
        osc_core <= core_choice;
      end else begin
        osc_core <= cal_core;
      end
      if (cap_ovr) begin
        // code as written; codes above 183 are unused by the bank
        cap_bank_code <= cap_bank_q[`OCD_CAP_HI:`OCD_CAP_LO];
      end else begin
        // automatic search output left for analog loop; hold midscale-free
        cap_bank_code <= `OCD_RST_CAP_CODE;
      end
    end
  end

  // modulator and distribution controls
  always @(posedge clock) begin
    if (rst) begin
      modulator_dither    <= 1'b0;
      tuning_adjust       <= 2'h0;
      out_b_direct_buf_pd <= `OCD_RST_DISTB_PD;
      out_a_direct_buf_pd <= 1'b0;
      divider_feed_buf_pd <= 1'b0;
    end else begin
      modulator_dither    <= mod_tune_q[`OCD_DITHER_BIT];
      tuning_adjust       <= mod_tune_q[`OCD_TUNE_HI:`OCD_TUNE_LO];
      out_b_direct_buf_pd <= dist_pd_q[`OCD_DISTB_BIT];
      out_a_direct_buf_pd <= dist_pd_q[`OCD_DISTA_BIT];
      divider_feed_buf_pd <= dist_pd_q[`OCD_DIVFEED_BIT];
    end
  end

  // read mux: data one cycle after rd, zero otherwise or unmapped
  always @(posedge clock) begin
    if (rst || !rd) begin
      rdata <= 16'h0000;
    end else begin
      case (addr)
        `OCD_IDX_AMP_START: rdata <= amp_start_q;
        `OCD_IDX_CAP_BANK:  rdata <= cap_bank_q;
        `OCD_IDX_CORE_SEL:  rdata <= core_sel_q;
        `OCD_IDX_FIXED_A:   rdata <= fixed_a_q;
        `OCD_IDX_FIXED_B:   rdata <= fixed_b_q;
        `OCD_IDX_FIXED_C:   rdata <= fixed_c_q;
        `OCD_IDX_FIXED_D:   rdata <= fixed_d_q;
        `OCD_IDX_MOD_TUNE:  rdata <= mod_tune_q;
        `OCD_IDX_DIST_PD:   rdata <= dist_pd_q;
        `OCD_IDX_CAL_CTRL:  rdata <= cal_ctrl_q;
        // live engine state
        `OCD_IDX_STATUS: rdata <= {2'h0, amp_busy, frq_busy,
                                   cal_core, amp_code};
        default:            rdata <= 16'h0000;
      endcase
    end
  end
endmodule // ocd_regs

// *** shared/ocd_defs.vh ***
// constants for the oscillator calibration and distribution register slice
// assumes: included by the core files; 16-bit registers, 5-bit index bus
`ifndef OCD_DEFS_VH
`define OCD_DEFS_VH

// register indices (chosen map; 5-bit address)
`define OCD_ADDR_W          5
`define OCD_IDX_AMP_START   5'h14
`define OCD_IDX_CAP_BANK    5'h16
`define OCD_IDX_CORE_SEL    5'h17
`define OCD_IDX_FIXED_A     5'h18
`define OCD_IDX_FIXED_B     5'h19
`define OCD_IDX_FIXED_C     5'h1c
`define OCD_IDX_FIXED_D     5'h1d
`define OCD_IDX_MOD_TUNE    5'h1e
`define OCD_IDX_DIST_PD     5'h1f
`define OCD_IDX_CAL_CTRL    5'h01
`define OCD_IDX_STATUS      5'h02

// reset values
`define OCD_RST_AMP_START   16'h012c
`define OCD_RST_CAP_BANK    16'h0000
`define OCD_RST_CORE_SEL    16'h0800
`define OCD_RST_ZERO        16'h0000
`define OCD_RST_DIST_PD     16'h0400
`define OCD_RST_CAL_CTRL    16'h0000
// reset levels of single outputs, sized to the output itself
`define OCD_RST_CAP_CODE    8'h00
`define OCD_RST_DISTB_PD    1'b1

// field positions
`define OCD_AMP_START_HI    8
`define OCD_AMP_START_LO    0
`define OCD_CAP_HI          7
`define OCD_CAP_LO          0
`define OCD_START_CORE_BIT  14
`define OCD_CORE_HI         13
`define OCD_CORE_LO         11
`define OCD_FORCE_BIT       10
`define OCD_DITHER_BIT      10
`define OCD_TUNE_HI         7
`define OCD_TUNE_LO         6
`define OCD_DISTB_BIT       10
`define OCD_DISTA_BIT       9
`define OCD_DIVFEED_BIT     7
// calibration control register bits
`define OCD_AMP_OVR_BIT     0
`define OCD_CAP_OVR_BIT     1
`define OCD_AMP_CAL_EN_BIT  2
`define OCD_FREQ_CAL_EN_BIT 3
`define OCD_AMP_CODE_HI     12
`define OCD_AMP_CODE_LO     4

// calibration constants
`define OCD_DEFAULT_CORE    3'h7
`define OCD_CAP_MAX         8'hb7
`define OCD_AMP_MIN         9'h0fa
`define OCD_AMP_MAX         9'h1c2
`define OCD_AMP_CODE_RST    9'h12c

`endif

// *** test/ocd_regs_asserts.sv ***
// checker: port relations of the oscillator register slice
// assumes: bound to ocd_regs; one clock, synchronous reset
`timescale 1ns/1ps
module ocd_regs_asserts (
  input wire        clock,
  input wire        rst,
  input wire [4:0]  addr,
  input wire [15:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [15:0] rdata,
  input wire [8:0]  osc_amplitude_code,
  input wire        modulator_dither,
  input wire [1:0]  tuning_adjust,
  input wire        out_b_direct_buf_pd,
  input wire        out_a_direct_buf_pd,
  input wire        divider_feed_buf_pd
);
  // all checks share the one clock and its reset
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data not idle");
  a_outb_follow: assert property (wr && addr == 5'h1f |-> ##2
    out_b_direct_buf_pd == $past(wdata[10], 2))
    else $error("output b buffer power-down wrong");
  a_outa_follow: assert property (wr && addr == 5'h1f |-> ##2
    out_a_direct_buf_pd == $past(wdata[9], 2))
    else $error("output a buffer power-down wrong");
  a_divfeed_follow: assert property (wr && addr == 5'h1f |-> ##2
    divider_feed_buf_pd == $past(wdata[7], 2))
    else $error("divider buffer power-down wrong");
  a_dither_follow: assert property (wr && addr == 5'h1e |-> ##2
    modulator_dither == $past(wdata[10], 2))
    else $error("dither bit wrong");
  a_tune_follow: assert property (wr && addr == 5'h1e |-> ##2
    tuning_adjust == $past(wdata[7:6], 2))
    else $error("tuning adjust wrong");
  a_amp_override: assert property (wr && addr == 5'h01 && wdata[0]
    |-> ##3 osc_amplitude_code == $past(wdata[12:4], 3))
    else $error("manual amplitude code not applied");
  // the output b buffer setting only moves after a write to its register
  a_outb_hold: assert property (!(wr && addr == 5'h1f) |-> ##2
    $stable(out_b_direct_buf_pd)) else $error("output b changed alone");
endmodule // ocd_regs_asserts

bind ocd_regs ocd_regs_asserts u_ocd_regs_asserts (.*);

// *** test/ocd_regs_tb.sv ***
// testbench for the oscillator calibration register slice
// assumes: ocd_regs with read data one cycle after the read strobe
`timescale 1ns/1ps
module ocd_regs_tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        amp_cal_start = 1'b0;
  logic        freq_cal_start = 1'b0;
  logic        amp_target = 1'b1;
  logic        freq_target = 1'b0;
  wire [15:0]  rdata;
  wire [8:0]   osc_amplitude_code;
  wire [2:0]   osc_core;
  wire [7:0]   cap_bank_code;
  wire         modulator_dither;
  wire [1:0]   tuning_adjust;
  wire         out_b_direct_buf_pd;
  wire         out_a_direct_buf_pd;
  wire         divider_feed_buf_pd;
  int          n_fail = 0;   // mismatches
  int          checks = 0;   // comparisons
  int          cyc = 0;      // cycle count for the hang limit
  logic [15:0] rv;           // last read value
  logic [20:0] rows [0:8];   // {index, value}, value reads back whole

  ocd_regs u_ocd_regs (.*);

  initial forever #2.5 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe beside index and data
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // data taken only in the cycle after the strobe
  task automatic rreg(input logic [4:0] a);
    @(posedge clock);
    addr <= a; rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // outputs other than osc_amplitude_code land one edge after the register takes a write
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse(input bit f);
    @(posedge clock);
    if (f) freq_cal_start <= 1'b1; else amp_cal_start <= 1'b1;
    @(posedge clock);
    freq_cal_start <= 1'b0; amp_cal_start <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang limit well above the few hundred cycles of the sequence
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run;
    end
  end

  initial begin
    rows = '{{5'h14, 16'h01c2}, {5'h16, 16'h00b7}, {5'h17, 16'h0800},
             {5'h18, 16'ha5a5}, {5'h19, 16'h5a5a}, {5'h1c, 16'hffff},
             {5'h1d, 16'h0001}, {5'h1e, 16'h04c0}, {5'h1f, 16'h0680}};
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    settle(1);
    check({7'h0, osc_amplitude_code}, 16'h012c);
    check({13'h0, osc_core}, 16'h0007);
    check({8'h0, cap_bank_code}, 16'h0000);
    check({13'h0, out_b_direct_buf_pd, out_a_direct_buf_pd,
           divider_feed_buf_pd}, 16'h0004);
    rreg(5'h14); check(rv, 16'h012c);
    rreg(5'h17); check(rv, 16'h0800);
    rreg(5'h1f); check(rv, 16'h0400);
    $display("test reset values done");
    foreach (rows[i]) begin
      wreg(rows[i][20:16], rows[i][15:0]);
      rreg(rows[i][20:16]);
      check(rv, rows[i][15:0]);
    end
    check({13'h0, modulator_dither, tuning_adjust}, 16'h0007);
    check({13'h0, out_b_direct_buf_pd, out_a_direct_buf_pd,
           divider_feed_buf_pd}, 16'h0007);
    wreg(5'h1e, 16'h0000);
    wreg(5'h1f, 16'h0000);
    settle(1);
    check({13'h0, modulator_dither, tuning_adjust}, 16'h0000);
    check({13'h0, out_b_direct_buf_pd, out_a_direct_buf_pd,
           divider_feed_buf_pd}, 16'h0000);
    wreg(5'h05, 16'hffff);
    rreg(5'h05); check(rv, 16'h0000);
    $display("test table and unmapped done");
    wreg(5'h01, 16'h1a51);
    settle(2);
    check({7'h0, osc_amplitude_code}, 16'h01a5);
    wreg(5'h14, 16'h00fa);
    wreg(5'h01, 16'h0004);
    pulse(1'b0);
    settle(3);
    check({7'h0, osc_amplitude_code}, 16'h00fa);
    amp_target <= 1'b0;
    pulse(1'b0);
    settle(260);
    check({7'h0, osc_amplitude_code}, 16'h01c2);
    amp_target <= 1'b1;
    $display("test amplitude done");
    wreg(5'h01, 16'h0008);
    pulse(1'b1);
    settle(12);
    check({13'h0, osc_core}, 16'h0000);
    freq_target <= 1'b1;
    pulse(1'b1);
    settle(4);
    check({13'h0, osc_core}, 16'h0007);
    wreg(5'h17, 16'h5800);
    pulse(1'b1);
    settle(4);
    check({13'h0, osc_core}, 16'h0003);
    wreg(5'h17, 16'h2c00);
    wreg(5'h01, 16'h0002);
    settle(2);
    check({13'h0, osc_core}, 16'h0005);
    check({8'h0, cap_bank_code}, 16'h00b7);
    $display("test calibration done");
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rreg(5'h1f); check(rv, 16'h0400);
    $display("test second reset done");
    complete_run;
  end
endmodule // ocd_regs_tb
